// ===== hw/port_cfg_pkg.sv
// Offsets, field positions and reset values of the port configuration slice
`default_nettype none
package port_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_DEV_CAP2 = 12'h0e4;
  localparam logic [11:0] OFF_DEV_CTL_STS2 = 12'h0e8;
  localparam logic [11:0] OFF_LINK_CAP2 = 12'h0ec;
  localparam logic [11:0] OFF_LINK_CTL_STS2 = 12'h0f0;
  localparam logic [11:0] OFF_SLOT_CAP2 = 12'h0f4;
  localparam logic [11:0] OFF_SLOT_CTL_STS2 = 12'h0f8;
  localparam logic [11:0] OFF_ERR_CAP_HDR = 12'h100;
  localparam logic [11:0] OFF_UNCOR_ERR = 12'h104;
  // Device capabilities two
  localparam int LTR_SUP_BIT = 11;
  localparam int OBFF_SUP_LSB = 18;
  localparam logic [1:0] OBFF_SUP_VAL = 2'h1;
  // Device control two
  localparam int LTR_EN_BIT = 10;
  localparam int OBFF_EN_LSB = 13;
  localparam logic [1:0] OBFF_EN_RST = 2'h0;
  // Link control and status two
  localparam int TGT_SPEED_LSB = 0;
  localparam logic [3:0] TGT_SPEED_RST = 4'h2;
  localparam int ENTER_COMPL_BIT = 4;
  localparam int HW_SPEED_INH_BIT = 5;
  localparam int SEL_DEEMPH_BIT = 6;
  localparam int TX_MARGIN_LSB = 7;
  localparam int ENTER_MOD_COMPL_BIT = 10;
  localparam int COMPL_SOS_BIT = 11;
  localparam int COMPL_DEEMPH_BIT = 12;
  localparam int CUR_DEEMPH_BIT = 16;
  // Error reporting header
  localparam logic [15:0] ERR_CAP_ID = 16'h0001;
  localparam logic [3:0] ERR_CAP_VER = 4'h1;
  localparam logic [11:0] ERR_NEXT_PTR = 12'h140;
  // Uncorrectable_error_flags
  localparam int UE_TRAIN = 0;
  localparam int UE_DLP = 4;
  localparam int UE_SDN = 5;
  localparam int UE_POISON = 12;
  localparam int UE_FCP = 13;
  localparam int UE_CTO = 14;
  localparam int UE_CA = 15;
  localparam int UE_UC = 16;
  localparam int UE_RXOVF = 17;
  localparam int UE_MALF = 18;
  localparam int UE_ECRC = 19;
  localparam int UE_UR = 20;
  localparam int UE_ACS = 21;
  localparam int UE_NUM = 13;
  localparam logic [31:0] UE_IMPL_MASK = 32'h003ff031;
  localparam logic [31:0] UE_DSP_ONLY_MASK = 32'h00000020;
endpackage
`default_nettype wire

// ===== hw/sticky_flag.sv
// One write-one-to-clear sticky error flag
`default_nettype none
module sticky_flag (
  input wire logic sys_clk,
  input wire logic pwr_rst_n,
  input wire logic enable,
  input wire logic event_in,
  input wire logic clear,
  output logic flag
);
  typedef struct packed {
    logic flag_r;
  } flag_state_t;
  flag_state_t st_r;
  flag_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Set wins over a clear in the same cycle
    if (clear) begin
      st_nxt.flag_r = 1'b0;
    end
    if (event_in && enable) begin
      st_nxt.flag_r = 1'b1;
    end
  end

  // Only a power-on reset reaches this flop, so the flag survives port resets
  always_ff @(posedge sys_clk or negedge pwr_rst_n) begin
    if (!pwr_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag_r;
endmodule
`default_nettype wire

// ===== hw/port_cfg_regs.sv
// Port configuration slice: second capability set, error header and error status
`default_nettype none
// Behaviour
// - Latency tolerance supported bit reads one
// - Buffer flush/fill supported field reads 01
// - Latency and flush/fill enables writable, reset zero
// - De-emphasis select read-only, reset by port role
// - Error header identifier reads 0001h
// - Error header version reads 1h
// - Error header next pointer reads 140h
// - Training error flag set by event
// - Link protocol error flag set by event
// - Surprise down flag, downstream ports only
// - Poisoned packet flag, received or generated
// - Flow control protocol error flag set
// - Completion timeout flag set by event
// - Completer abort flag set by event
// - Unexpected completion flag set by event
// - Receiver overflow flag set by event
// - Malformed packet flag set by event
// - End-to-end CRC error flag set
// - Unsupported request flag set by event
// - Access control violation flag set
module port_cfg_regs #(
  parameter bit DOWNSTREAM = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pwr_rst_n,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [31:0] cfg_rdata,
  input wire logic ev_training_err,
  input wire logic ev_dl_protocol_err,
  input wire logic ev_surprise_down,
  input wire logic ev_poisoned_tlp,
  input wire logic ev_fc_protocol_err,
  input wire logic ev_cpl_timeout,
  input wire logic ev_completer_abort,
  input wire logic ev_unexpected_cpl,
  input wire logic ev_rx_overflow,
  input wire logic ev_malformed_tlp,
  input wire logic ev_ecrc_err,
  input wire logic ev_unsupported_req,
  input wire logic ev_acs_violation,
  input wire logic cur_deemph_level,
  output logic ltr_enable,
  output logic [1:0] obff_enable,
  output logic [3:0] target_link_speed,
  output logic enter_compliance,
  output logic hardware_speed_change_inhibit,
  output logic [2:0] transmit_margin,
  output logic enter_mod_compliance,
  output logic compliance_skip_ordered_sets,
  output logic compliance_deemph
);
  typedef struct packed {
    logic [31:0] rdata_r;
    logic ltr_en_r;
    logic [1:0] obff_en_r;
    logic hw_inh_r;
  } port_state_t;
  typedef struct packed {
    logic [3:0] speed_r;
    logic compl_r;
    logic [2:0] margin_r;
    logic mod_compl_r;
    logic sos_r;
    logic cdeemph_r;
  } sticky_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  sticky_state_t sk_r;
  sticky_state_t sk_nxt;
  logic [31:0] ue_flags;
  logic [31:0] ue_events;
  logic [31:0] ue_clear;
  logic [31:0] rd_val;
  logic [15:0] link_ctl;
  logic sel_deemph;
  logic wr_dev_ctl;
  logic wr_link_ctl;

  // Flag count and the number of bits set in the implemented mask must agree
  if ($countones(port_cfg_pkg::UE_IMPL_MASK) != port_cfg_pkg::UE_NUM) begin : g_mask_check
    $error("implemented flag mask and flag count disagree");
  end

  assign sel_deemph = DOWNSTREAM;
  assign wr_dev_ctl = cfg_wr && (cfg_addr == port_cfg_pkg::OFF_DEV_CTL_STS2);
  assign wr_link_ctl = cfg_wr && (cfg_addr == port_cfg_pkg::OFF_LINK_CTL_STS2);

  always_comb begin
    ue_events = 32'h0;
    ue_events[port_cfg_pkg::UE_TRAIN] = ev_training_err;
    ue_events[port_cfg_pkg::UE_DLP] = ev_dl_protocol_err;
    ue_events[port_cfg_pkg::UE_SDN] = ev_surprise_down;
    ue_events[port_cfg_pkg::UE_POISON] = ev_poisoned_tlp;
    ue_events[port_cfg_pkg::UE_FCP] = ev_fc_protocol_err;
    ue_events[port_cfg_pkg::UE_CTO] = ev_cpl_timeout;
    ue_events[port_cfg_pkg::UE_CA] = ev_completer_abort;
    ue_events[port_cfg_pkg::UE_UC] = ev_unexpected_cpl;
    ue_events[port_cfg_pkg::UE_RXOVF] = ev_rx_overflow;
    ue_events[port_cfg_pkg::UE_MALF] = ev_malformed_tlp;
    ue_events[port_cfg_pkg::UE_ECRC] = ev_ecrc_err;
    ue_events[port_cfg_pkg::UE_UR] = ev_unsupported_req;
    ue_events[port_cfg_pkg::UE_ACS] = ev_acs_violation;
  end

  // Only a write to the status word clears, and only where a one is written
  assign ue_clear = (cfg_wr && (cfg_addr == port_cfg_pkg::OFF_UNCOR_ERR)) ?
                    cfg_wdata : 32'h0;

  for (genvar i = 0; i < 32; i++) begin : g_ue
    if (port_cfg_pkg::UE_IMPL_MASK[i]) begin : g_impl
      // Surprise down has no meaning on the upstream port
      localparam bit EN = !port_cfg_pkg::UE_DSP_ONLY_MASK[i] || DOWNSTREAM;
      sticky_flag u_flag (
        .sys_clk(sys_clk),
        .pwr_rst_n(pwr_rst_n),
        .enable(EN),
        .event_in(ue_events[i]),
        .clear(ue_clear[i]),
        .flag(ue_flags[i])
      );
    end else begin : g_rsvd
      assign ue_flags[i] = 1'b0;
    end
  end

  always_comb begin
    link_ctl = 16'h0;
    link_ctl[port_cfg_pkg::TGT_SPEED_LSB +: 4] = sk_r.speed_r;
    link_ctl[port_cfg_pkg::ENTER_COMPL_BIT] = sk_r.compl_r;
    link_ctl[port_cfg_pkg::HW_SPEED_INH_BIT] = st_r.hw_inh_r;
    link_ctl[port_cfg_pkg::SEL_DEEMPH_BIT] = sel_deemph;
    link_ctl[port_cfg_pkg::TX_MARGIN_LSB +: 3] = sk_r.margin_r;
    link_ctl[port_cfg_pkg::ENTER_MOD_COMPL_BIT] = sk_r.mod_compl_r;
    link_ctl[port_cfg_pkg::COMPL_SOS_BIT] = sk_r.sos_r;
    link_ctl[port_cfg_pkg::COMPL_DEEMPH_BIT] = sk_r.cdeemph_r;
  end

  // Read mux; unmapped offsets and reserved fields read zero
  always_comb begin
    rd_val = 32'h0;
    unique case (cfg_addr)
      port_cfg_pkg::OFF_DEV_CAP2: begin
        rd_val[port_cfg_pkg::LTR_SUP_BIT] = 1'b1;
        rd_val[port_cfg_pkg::OBFF_SUP_LSB +: 2] = port_cfg_pkg::OBFF_SUP_VAL;
      end
      port_cfg_pkg::OFF_DEV_CTL_STS2: begin
        rd_val[port_cfg_pkg::LTR_EN_BIT] = st_r.ltr_en_r;
        rd_val[port_cfg_pkg::OBFF_EN_LSB +: 2] = st_r.obff_en_r;
      end
      port_cfg_pkg::OFF_LINK_CTL_STS2: begin
        rd_val[15:0] = link_ctl;
        rd_val[port_cfg_pkg::CUR_DEEMPH_BIT] = cur_deemph_level;
      end
      port_cfg_pkg::OFF_ERR_CAP_HDR: begin
        rd_val = {port_cfg_pkg::ERR_NEXT_PTR, port_cfg_pkg::ERR_CAP_VER,
                  port_cfg_pkg::ERR_CAP_ID};
      end
      port_cfg_pkg::OFF_UNCOR_ERR: begin
        rd_val = ue_flags & port_cfg_pkg::UE_IMPL_MASK;
      end
      default: begin
        rd_val = 32'h0;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata_r = cfg_rd ? rd_val : 32'h0;
    if (wr_dev_ctl) begin
      st_nxt.ltr_en_r = cfg_wdata[port_cfg_pkg::LTR_EN_BIT];
      st_nxt.obff_en_r = cfg_wdata[port_cfg_pkg::OBFF_EN_LSB +: 2];
    end
    if (wr_link_ctl) begin
      st_nxt.hw_inh_r = cfg_wdata[port_cfg_pkg::HW_SPEED_INH_BIT];
    end
  end

  always_comb begin
    sk_nxt = sk_r;
    if (wr_link_ctl) begin
      sk_nxt.speed_r = cfg_wdata[port_cfg_pkg::TGT_SPEED_LSB +: 4];
      sk_nxt.compl_r = cfg_wdata[port_cfg_pkg::ENTER_COMPL_BIT];
      sk_nxt.margin_r = cfg_wdata[port_cfg_pkg::TX_MARGIN_LSB +: 3];
      sk_nxt.mod_compl_r = cfg_wdata[port_cfg_pkg::ENTER_MOD_COMPL_BIT];
      sk_nxt.sos_r = cfg_wdata[port_cfg_pkg::COMPL_SOS_BIT];
      sk_nxt.cdeemph_r = cfg_wdata[port_cfg_pkg::COMPL_DEEMPH_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.obff_en_r <= port_cfg_pkg::OBFF_EN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Sticky link settings follow the power-on reset only
  always_ff @(posedge sys_clk or negedge pwr_rst_n) begin
    if (!pwr_rst_n) begin
      sk_r <= '0;
      sk_r.speed_r <= port_cfg_pkg::TGT_SPEED_RST;
    end else begin
      sk_r <= sk_nxt;
    end
  end

  assign cfg_rdata = st_r.rdata_r;
  assign ltr_enable = st_r.ltr_en_r;
  assign obff_enable = st_r.obff_en_r;
  assign hardware_speed_change_inhibit = st_r.hw_inh_r;
  assign target_link_speed = sk_r.speed_r;
  assign enter_compliance = sk_r.compl_r;
  assign transmit_margin = sk_r.margin_r;
  assign enter_mod_compliance = sk_r.mod_compl_r;
  assign compliance_skip_ordered_sets = sk_r.sos_r;
  assign compliance_deemph = sk_r.cdeemph_r;

  // Each event but surprise down on the upstream port must show in its flag at the very next edge; set wins over clear
  AST_TRAIN_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_training_err |=> ue_flags[port_cfg_pkg::UE_TRAIN])
    else $error("training flag not set");
  AST_DLP_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_dl_protocol_err |=> ue_flags[port_cfg_pkg::UE_DLP])
    else $error("link protocol flag not set");
  AST_SDN_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    (DOWNSTREAM && ev_surprise_down) |=> ue_flags[port_cfg_pkg::UE_SDN])
    else $error("surprise down flag not set");
  AST_SDN_UPSTREAM: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    !DOWNSTREAM |-> !ue_flags[port_cfg_pkg::UE_SDN])
    else $error("surprise down set on upstream port");
  AST_POISON_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_poisoned_tlp |=> ue_flags[port_cfg_pkg::UE_POISON])
    else $error("poisoned packet flag not set");
  AST_FCP_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_fc_protocol_err |=> ue_flags[port_cfg_pkg::UE_FCP])
    else $error("flow control flag not set");
  AST_CTO_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_cpl_timeout |=> ue_flags[port_cfg_pkg::UE_CTO])
    else $error("completion timeout flag not set");
  AST_CA_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_completer_abort |=> ue_flags[port_cfg_pkg::UE_CA])
    else $error("completer abort flag not set");
  AST_UC_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_unexpected_cpl |=> ue_flags[port_cfg_pkg::UE_UC])
    else $error("unexpected completion flag not set");
  AST_RXOVF_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_rx_overflow |=> ue_flags[port_cfg_pkg::UE_RXOVF])
    else $error("receiver overflow flag not set");
  AST_MALF_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_malformed_tlp |=> ue_flags[port_cfg_pkg::UE_MALF])
    else $error("malformed packet flag not set");
  AST_ECRC_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_ecrc_err |=> ue_flags[port_cfg_pkg::UE_ECRC])
    else $error("end-to-end crc flag not set");
  AST_UR_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_unsupported_req |=> ue_flags[port_cfg_pkg::UE_UR])
    else $error("unsupported request flag not set");
  AST_ACS_SET: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_acs_violation |=> ue_flags[port_cfg_pkg::UE_ACS])
    else $error("access control flag not set");

  // Only a written one clears; a zero or a colliding event keeps the flag
  AST_W1C_CLEAR: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    (ue_clear[port_cfg_pkg::UE_UR] && !ev_unsupported_req)
    |=> !ue_flags[port_cfg_pkg::UE_UR])
    else $error("write one did not clear");
  AST_W0_KEEP: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    (ue_flags[port_cfg_pkg::UE_MALF] && !ue_clear[port_cfg_pkg::UE_MALF])
    |=> ue_flags[port_cfg_pkg::UE_MALF])
    else $error("flag lost without clear");
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    (ev_cpl_timeout && ue_clear[port_cfg_pkg::UE_CTO])
    |=> ue_flags[port_cfg_pkg::UE_CTO])
    else $error("event lost against clear");

  // Read data answer one cycle after the strobe and fall back to zero
  AST_HDR_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_rd && cfg_addr == port_cfg_pkg::OFF_ERR_CAP_HDR)
    |=> cfg_rdata == 32'h14010001)
    else $error("error header value wrong");
  AST_HDR_ID: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_rd && cfg_addr == port_cfg_pkg::OFF_ERR_CAP_HDR)
    |=> cfg_rdata[15:0] == 16'h0001)
    else $error("error header identifier wrong");
  AST_HDR_VER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_rd && cfg_addr == port_cfg_pkg::OFF_ERR_CAP_HDR)
    |=> cfg_rdata[19:16] == 4'h1)
    else $error("error header version wrong");
  AST_CAP_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_rd && cfg_addr == port_cfg_pkg::OFF_DEV_CAP2)
    |=> cfg_rdata == 32'h00040800)
    else $error("device capability value wrong");
  AST_OBFF_SUP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_rd && cfg_addr == port_cfg_pkg::OFF_DEV_CAP2)
    |=> cfg_rdata[19:18] == 2'h1)
    else $error("flush/fill support field wrong");
  AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_rd && cfg_addr == port_cfg_pkg::OFF_UNCOR_ERR)
    |=> (cfg_rdata & ~32'h003ff031) == 32'h0)
    else $error("reserved status bits nonzero");
  AST_DEEMPH_RO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_rd && cfg_addr == port_cfg_pkg::OFF_LINK_CTL_STS2)
    |=> cfg_rdata[6] == DOWNSTREAM)
    else $error("de-emphasis select wrong");
  AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cfg_rd |=> cfg_rdata == 32'h0)
    else $error("read data outside read slot");

  // Control fields move only on a write to their own word
  AST_CTL_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_dev_ctl |=> (ltr_enable == $past(cfg_wdata[10])) &&
    (obff_enable == $past(cfg_wdata[14:13])))
    else $error("device control write lost");
  AST_DEVCTL_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_dev_ctl |=> $stable(ltr_enable) && $stable(obff_enable))
    else $error("device control changed without write");

  COV_W1C: cover property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ue_flags[port_cfg_pkg::UE_TRAIN] ##1 ue_clear[port_cfg_pkg::UE_TRAIN]);
  COV_COLLIDE: cover property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    ev_cpl_timeout && ue_clear[port_cfg_pkg::UE_CTO]);
  COV_CTL_WR: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_link_ctl);
  COV_SDN: cover property (@(posedge sys_clk) disable iff (!pwr_rst_n)
    DOWNSTREAM && ev_surprise_down);
  COV_RD_ERR: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == port_cfg_pkg::OFF_UNCOR_ERR);
endmodule
`default_nettype wire

// ===== sim/port_cfg_regs_tb.sv
// Self-checking bench for the port configuration slice
`default_nettype none
module port_cfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pwr_rst_n = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [31:0] cfg_wdata = 32'h0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [31:0] cfg_rdata;
  logic [12:0] ev = 13'h0;
  logic cur_deemph_level = 1'b0;
  logic ltr_enable;
  logic [1:0] obff_enable;
  logic [3:0] target_link_speed;
  logic enter_compliance;
  logic hardware_speed_change_inhibit;
  logic [2:0] transmit_margin;
  logic enter_mod_compliance;
  logic compliance_skip_ordered_sets;
  logic compliance_deemph;
  logic [31:0] ctl_out;
  logic [31:0] up_rdata;
  int errors = 0;
  int total_checks = 0;

  // Downstream role so that the surprise down flag can be seen to set
  port_cfg_regs #(.DOWNSTREAM(1'b1)) DUT (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pwr_rst_n(pwr_rst_n),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata),
    .ev_training_err(ev[0]),
    .ev_dl_protocol_err(ev[1]),
    .ev_surprise_down(ev[2]),
    .ev_poisoned_tlp(ev[3]),
    .ev_fc_protocol_err(ev[4]),
    .ev_cpl_timeout(ev[5]),
    .ev_completer_abort(ev[6]),
    .ev_unexpected_cpl(ev[7]),
    .ev_rx_overflow(ev[8]),
    .ev_malformed_tlp(ev[9]),
    .ev_ecrc_err(ev[10]),
    .ev_unsupported_req(ev[11]),
    .ev_acs_violation(ev[12]),
    .cur_deemph_level(cur_deemph_level),
    .ltr_enable(ltr_enable),
    .obff_enable(obff_enable),
    .target_link_speed(target_link_speed),
    .enter_compliance(enter_compliance),
    .hardware_speed_change_inhibit(hardware_speed_change_inhibit),
    .transmit_margin(transmit_margin),
    .enter_mod_compliance(enter_mod_compliance),
    .compliance_skip_ordered_sets(compliance_skip_ordered_sets),
    .compliance_deemph(compliance_deemph)
  );

  // Upstream role on the same stimulus shows the role-dependent bits
  port_cfg_regs #(.DOWNSTREAM(1'b0)) DUT_UP (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pwr_rst_n(pwr_rst_n),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_rdata(up_rdata),
    .ev_training_err(ev[0]),
    .ev_dl_protocol_err(ev[1]),
    .ev_surprise_down(ev[2]),
    .ev_poisoned_tlp(ev[3]),
    .ev_fc_protocol_err(ev[4]),
    .ev_cpl_timeout(ev[5]),
    .ev_completer_abort(ev[6]),
    .ev_unexpected_cpl(ev[7]),
    .ev_rx_overflow(ev[8]),
    .ev_malformed_tlp(ev[9]),
    .ev_ecrc_err(ev[10]),
    .ev_unsupported_req(ev[11]),
    .ev_acs_violation(ev[12]),
    .cur_deemph_level(cur_deemph_level),
    .ltr_enable(),
    .obff_enable(),
    .target_link_speed(),
    .enter_compliance(),
    .hardware_speed_change_inhibit(),
    .transmit_margin(),
    .enter_mod_compliance(),
    .compliance_skip_ordered_sets(),
    .compliance_deemph()
  );

  assign ctl_out = {17'h0, ltr_enable, obff_enable, target_link_speed, enter_compliance,
                    hardware_speed_change_inhibit, transmit_margin, enter_mod_compliance,
                    compliance_skip_ordered_sets, compliance_deemph};

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    check(what, exp, cfg_rdata);
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk);
    ev <= 13'h1 << k;
    @(posedge sys_clk);
    ev <= 13'h0;
  endtask

  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end

  initial begin
    int pos;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    pwr_rst_n <= 1'b1;
    #1;
    check("ctl_reset", 32'h00000200, ctl_out);
    rd(12'h0e4, 32'h00040800, "dev_cap2");
    rd(12'h0e8, 32'h00000000, "dev_ctl2");
    rd(12'h0f0, 32'h00000042, "link_ctl2");
    check("link_ctl2_up", 32'h00000002, up_rdata);
    rd(12'h0ec, 32'h00000000, "link_cap2");
    rd(12'h0f4, 32'h00000000, "slot_cap2");
    rd(12'h0f8, 32'h00000000, "slot_ctl2");
    rd(12'h100, 32'h14010001, "err_hdr");
    rd(12'h104, 32'h00000000, "uncor");
    rd(12'h200, 32'h00000000, "unmapped");
    // Read-only places must shrug off an all-ones write
    wr(12'h0e4, 32'hffffffff);
    wr(12'h100, 32'hffffffff);
    wr(12'h0e8, 32'hffffffff);
    wr(12'h0f0, 32'hffffffbf);
    wr(12'h200, 32'hffffffff);
    rd(12'h0e4, 32'h00040800, "dev_cap2_ro");
    rd(12'h100, 32'h14010001, "err_hdr_ro");
    rd(12'h0e8, 32'h00006400, "dev_ctl2_w");
    rd(12'h0f0, 32'h00001fff, "link_ctl2_w");
    rd(12'h200, 32'h00000000, "unmapped_w");
    check("ctl_ones", 32'h00007fff, ctl_out);
    @(posedge sys_clk);
    cur_deemph_level <= 1'b1;
    rd(12'h0f0, 32'h00011fff, "link_sts2");
    wr(12'h0e8, 32'h00002000);
    rd(12'h0e8, 32'h00002000, "dev_ctl2_obff");
    wr(12'h0e8, 32'h00006400);
    // Walk every error source: set, ignore a zero write, clear with a one
    for (int k = 0; k < 13; k++) begin
      pos = (k == 0) ? 0 : (k < 3) ? k + 3 : k + 9;
      pulse(k);
      rd(12'h104, 32'h1 << pos, "uncor_set");
      check("uncor_up", (pos == 5) ? 32'h0 : 32'h1 << pos, up_rdata);
      wr(12'h104, ~(32'h1 << pos));
      rd(12'h104, 32'h1 << pos, "uncor_w0");
      wr(12'h104, 32'h1 << pos);
      rd(12'h104, 32'h0, "uncor_clr");
    end
    // An event in the very cycle of its clear must survive the clear
    @(posedge sys_clk);
    ev <= 13'h0020;
    cfg_wr <= 1'b1;
    cfg_addr <= 12'h104;
    cfg_wdata <= 32'h00004000;
    @(posedge sys_clk);
    ev <= 13'h0;
    cfg_wr <= 1'b0;
    rd(12'h104, 32'h00004000, "uncor_collide");
    wr(12'h104, 32'h00004000);
    // A port reset keeps sticky state; only the power-on reset wipes it
    pulse(10);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    check("ctl_port_rst", 32'h00000fbf, ctl_out);
    rd(12'h104, 32'h00080000, "uncor_sticky");
    rd(12'h0e8, 32'h00000000, "dev_ctl2_rst");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    pwr_rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    pwr_rst_n <= 1'b1;
    #1;
    check("ctl_pwr_rst", 32'h00000200, ctl_out);
    rd(12'h104, 32'h00000000, "uncor_pwr");
    tally_and_finish();
  end
endmodule
`default_nettype wire
